/* File: verilog/system_clock_source_select.sv */
// system clock source selector: source choice, oscillator enables, glitch-free switching, status
// Function
// - secondary crystal selectable at run time
// - rc mode clocks from input pin
// - output pin is gpio or clock out in internal and rc configurations
// - internal config code selects internal after reset
// - source select upper bit picks internal
// - internal mode frees the input pin
// - high oscillator derives from mid via pll
// - low 31 khz internal source provided
// - tune register trims high and mid
// - frequency select field picks postscaled frequency
// - high oscillator enable condition
// - mid oscillator enable condition
// - high ready flag when running
// - high locked flag within two percent
// - high stable flag within half percent
// - mid ready flag when running
`timescale 1ns/1ps

module system_clock_source_select (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // configuration straps
  input wire logic [2:0] osc_select_config_i,
  input wire logic clock_out_enable_cfg_i,
  // oscillator and pll status levels
  input wire logic hf_run_i,
  input wire logic mf_run_i,
  input wire logic lf_run_i,
  input wire logic sec_xtal_run_i,
  input wire logic ext_osc_run_i,
  input wire logic pll_lock_coarse_i,
  input wire logic pll_lock_fine_i,
  input wire logic clkout_src_i,
  // oscillator controls
  output logic hf_osc_en_o,
  output logic mf_osc_en_o,
  output logic lf_osc_en_o,
  output logic hf_pll_en_o,
  output logic sec_xtal_en_o,
  output logic ext_osc_en_o,
  output logic [2:0] clk_src_sel_o,
  output logic [3:0] postscale_o,
  output logic [5:0] osc_tune_o,
  // pins
  input wire logic gpio_out_i,
  input wire logic gpio_oe_i,
  output logic osc_in_gpio_o,
  output logic osc_out_o,
  output logic osc_out_oe_o,
  // interrupt
  output logic irq_o
);

  // synchronised pin levels
  logic [clk_src_pkg::PIN_W-1:0] pin_raw;
  logic [clk_src_pkg::PIN_W-1:0] pin_s;
  assign pin_raw = {clock_out_enable_cfg_i, osc_select_config_i, clkout_src_i, pll_lock_fine_i,
                    pll_lock_coarse_i, ext_osc_run_i, sec_xtal_run_i, lf_run_i, mf_run_i, hf_run_i};

  pin_sync #(.W(clk_src_pkg::PIN_W)) u_pin_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  wire hf_run_s = pin_s[0];
  wire mf_run_s = pin_s[1];
  wire lf_run_s = pin_s[2];
  wire sec_run_s = pin_s[3];
  wire ext_run_s = pin_s[4];
  wire coarse_s = pin_s[5];
  wire fine_s = pin_s[6];
  wire clkout_s = pin_s[7];
  wire [2:0] cfg_s = pin_s[10:8];
  wire clkout_cfg_s = pin_s[11];

  // registers
  logic [1:0] scs_q;
  logic [3:0] ircf_q;
  logic [5:0] tune_q;
  logic [3:0] irq_stat_q, irq_stat_d;
  logic [3:0] irq_mask_q;
  logic [7:0] rdata_q, rdata_d;
  logic [1:0] cap_cnt_q;
  logic cfg_ok_q;
  logic [2:0] cfg_q;
  logic clkout_en_q;
  logic hf_en_q, mf_en_q, lf_en_q, sec_en_q, ext_en_q;
  logic [3:0] postscale_q;
  logic osc_in_gpio_q, osc_out_q, osc_out_oe_q;
  logic [3:0] ev_prev_q;
  clk_src_pkg::src_t active_q, target_q;
  clk_src_pkg::sw_state_t sw_q;

  // register decode
  wire wr_ctrl = wr_i && (addr_i == clk_src_pkg::ADDR_CTRL);
  wire wr_tune = wr_i && (addr_i == clk_src_pkg::ADDR_TUNE);
  wire wr_istat = wr_i && (addr_i == clk_src_pkg::ADDR_IRQ_STAT);
  wire wr_imask = wr_i && (addr_i == clk_src_pkg::ADDR_IRQ_MASK);

  // frequency select class: high, mid or low internal oscillator
  wire ircf_hf = ircf_q >= clk_src_pkg::IRCF_HF_MIN;
  wire ircf_mf = !ircf_hf && (ircf_q >= clk_src_pkg::IRCF_MF_MIN);
  wire ircf_lf = !ircf_hf && !ircf_mf;
  clk_src_pkg::src_t int_src;
  assign int_src = ircf_hf ? clk_src_pkg::SRC_HF : (ircf_mf ? clk_src_pkg::SRC_MF : clk_src_pkg::SRC_LF);

  // requested source: select field first, then the captured configuration
  wire cfg_internal = cfg_ok_q && (cfg_q == clk_src_pkg::CFG_INTERNAL);
  wire cfg_rc = cfg_ok_q && (cfg_q == clk_src_pkg::CFG_EXT_RC);
  wire internal_on = scs_q[1] || cfg_internal || !cfg_ok_q;
  clk_src_pkg::src_t req_src;
  always_comb
  begin
    if (scs_q[1])
      req_src = int_src;
    else if (scs_q == clk_src_pkg::SCS_SECONDARY)
      req_src = clk_src_pkg::SRC_SECONDARY;
    else if (!cfg_ok_q || cfg_internal)
      req_src = int_src;
    else if (cfg_rc)
      req_src = clk_src_pkg::SRC_EXT_RC;
    else
      req_src = clk_src_pkg::SRC_PRIMARY;
  end

  // enables: old source stays on until the switch completes
  wire act_hf = active_q == clk_src_pkg::SRC_HF;
  wire act_mf = active_q == clk_src_pkg::SRC_MF;
  wire act_lf = active_q == clk_src_pkg::SRC_LF;
  wire act_int = act_hf || act_mf || act_lf;
  wire act_ext = (active_q == clk_src_pkg::SRC_PRIMARY) || (active_q == clk_src_pkg::SRC_EXT_RC);
  wire req_ext = (req_src == clk_src_pkg::SRC_PRIMARY) || (req_src == clk_src_pkg::SRC_EXT_RC);
  wire hf_en_d = (internal_on && ircf_hf) || act_hf;
  wire mf_en_d = (internal_on && ircf_mf) || act_mf || hf_en_d;
  wire lf_en_d = (internal_on && ircf_lf) || act_lf;
  wire sec_en_d = (req_src == clk_src_pkg::SRC_SECONDARY) || (active_q == clk_src_pkg::SRC_SECONDARY);
  wire ext_en_d = req_ext || act_ext;

  // readiness flags, forced low while the oscillator is off
  wire hf_ready = hf_en_q && hf_run_s;
  wire hf_locked = hf_ready && coarse_s;
  wire hf_stable = hf_locked && fine_s;
  wire mf_ready = mf_en_q && mf_run_s;
  wire lf_ready = lf_en_q && lf_run_s;
  wire sec_ready = sec_en_q && sec_run_s;
  wire ext_ready = ext_en_q && ext_run_s;

  // readiness of the source being switched to
  logic tgt_ready;
  always_comb
  begin
    case (target_q)
      clk_src_pkg::SRC_HF: tgt_ready = hf_ready;
      clk_src_pkg::SRC_MF: tgt_ready = mf_ready;
      clk_src_pkg::SRC_LF: tgt_ready = lf_ready;
      clk_src_pkg::SRC_SECONDARY: tgt_ready = sec_ready;
      default: tgt_ready = ext_ready;
    endcase
  end

  // postscaler setting follows the active internal source
  logic [3:0] postscale_d;
  always_comb
  begin
    if (act_hf)
      postscale_d = clk_src_pkg::HF_DIV_TOP - ircf_q;
    else if (act_mf)
      postscale_d = clk_src_pkg::MF_DIV_TOP - ircf_q;
    else
      postscale_d = 4'h0;
  end

  // pin ownership
  wire osc_in_free = act_int || cfg_internal;
  wire osc_out_free = cfg_internal || cfg_rc;
  wire osc_out_d = clkout_en_q ? clkout_s : gpio_out_i;
  wire osc_out_oe_d = osc_out_free && (clkout_en_q || gpio_oe_i);

  // interrupt events on rising flags and on switch completion
  wire switch_done = (sw_q == clk_src_pkg::SW_WAIT) && (target_q == req_src) && tgt_ready;
  logic [3:0] ev_lvl;
  logic [3:0] ev_pulse;
  assign ev_lvl = {mf_ready, hf_stable, hf_locked, 1'b0};
  assign ev_pulse = {ev_lvl[3:1] & ~ev_prev_q[3:1], switch_done};
  assign irq_stat_d = (wr_istat ? (irq_stat_q & ~wdata_i[3:0]) : irq_stat_q) | ev_pulse;

  // read mux, unmapped addresses read zero
  logic [7:0] status_val;
  assign status_val = {1'b0, sw_q == clk_src_pkg::SW_WAIT, sec_ready, hf_ready, mf_ready, lf_ready,
                       hf_locked, hf_stable};
  always_comb
  begin
    if (!rd_i)
      rdata_d = 8'h00;
    else if (addr_i == clk_src_pkg::ADDR_CTRL)
      rdata_d = {1'b0, ircf_q, 1'b0, scs_q};
    else if (addr_i == clk_src_pkg::ADDR_TUNE)
      rdata_d = {2'h0, tune_q};
    else if (addr_i == clk_src_pkg::ADDR_STATUS)
      rdata_d = status_val;
    else if (addr_i == clk_src_pkg::ADDR_IRQ_STAT)
      rdata_d = {4'h0, irq_stat_q};
    else if (addr_i == clk_src_pkg::ADDR_IRQ_MASK)
      rdata_d = {4'h0, irq_mask_q};
    else if (addr_i == clk_src_pkg::ADDR_ACTIVE)
      rdata_d = {5'h00, active_q};
    else
      rdata_d = 8'h00;
  end

  // software registers
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      scs_q <= clk_src_pkg::SCS_RST;
      ircf_q <= clk_src_pkg::IRCF_RST;
      tune_q <= clk_src_pkg::TUNE_RST;
      irq_mask_q <= clk_src_pkg::IRQ_MASK_RST;
      irq_stat_q <= 4'h0;
      rdata_q <= 8'h00;
    end
    else if (ce_i)
    begin
      if (wr_ctrl)
      begin
        scs_q <= wdata_i[clk_src_pkg::CTRL_SCS_LSB +: 2];
        ircf_q <= wdata_i[clk_src_pkg::CTRL_IRCF_LSB +: 4];
      end
      if (wr_tune)
        tune_q <= wdata_i[5:0];
      if (wr_imask)
        irq_mask_q <= wdata_i[3:0];
      irq_stat_q <= irq_stat_d;
      rdata_q <= rdata_d;
    end
  end

  // strap capture a few cycles after reset release
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cap_cnt_q <= 2'h0;
      cfg_ok_q <= 1'b0;
      cfg_q <= 3'h0;
      clkout_en_q <= 1'b0;
    end
    else if (ce_i && !cfg_ok_q)
    begin
      cap_cnt_q <= cap_cnt_q + 2'h1;
      if (cap_cnt_q == clk_src_pkg::CFG_CAPTURE_CYCLES)
      begin
        cfg_ok_q <= 1'b1;
        cfg_q <= cfg_s;
        clkout_en_q <= clkout_cfg_s;
      end
    end
  end

  // switch sequencer: hold the old source until the new one is ready
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sw_q <= clk_src_pkg::SW_IDLE;
      active_q <= clk_src_pkg::SRC_MF;
      target_q <= clk_src_pkg::SRC_MF;
    end
    else if (ce_i)
    begin
      case (sw_q)
        clk_src_pkg::SW_IDLE:
          if (req_src != active_q)
          begin
            target_q <= req_src;
            sw_q <= clk_src_pkg::SW_WAIT;
          end
        clk_src_pkg::SW_WAIT:
          if (target_q != req_src)
            target_q <= req_src;
          else if (tgt_ready)
          begin
            active_q <= target_q;
            sw_q <= clk_src_pkg::SW_IDLE;
          end
        default: sw_q <= clk_src_pkg::SW_IDLE;
      endcase
    end
  end

  // registered oscillator controls and pins
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hf_en_q <= 1'b0;
      mf_en_q <= 1'b1;
      lf_en_q <= 1'b0;
      sec_en_q <= 1'b0;
      ext_en_q <= 1'b0;
      postscale_q <= 4'h0;
      osc_in_gpio_q <= 1'b0;
      osc_out_q <= 1'b0;
      osc_out_oe_q <= 1'b0;
      ev_prev_q <= 4'h0;
    end
    else if (ce_i)
    begin
      hf_en_q <= hf_en_d;
      mf_en_q <= mf_en_d;
      lf_en_q <= lf_en_d;
      sec_en_q <= sec_en_d;
      ext_en_q <= ext_en_d;
      postscale_q <= postscale_d;
      osc_in_gpio_q <= osc_in_free;
      osc_out_q <= osc_out_d;
      osc_out_oe_q <= osc_out_oe_d;
      ev_prev_q <= ev_lvl;
    end
  end

  // outputs
  assign rdata_o = rdata_q;
  assign hf_osc_en_o = hf_en_q;
  assign mf_osc_en_o = mf_en_q;
  assign lf_osc_en_o = lf_en_q;
  assign hf_pll_en_o = hf_en_q;
  assign sec_xtal_en_o = sec_en_q;
  assign ext_osc_en_o = ext_en_q;
  assign clk_src_sel_o = active_q;
  assign postscale_o = postscale_q;
  assign osc_tune_o = tune_q;
  assign osc_in_gpio_o = osc_in_gpio_q;
  assign osc_out_o = osc_out_q;
  assign osc_out_oe_o = osc_out_oe_q;
  assign irq_o = |(irq_stat_q & irq_mask_q);

  // checks
  property p_hf_enable;
    @(posedge clk_i) disable iff (!arst_n_i) ce_i && internal_on && ircf_hf |=> hf_osc_en_o;
  endproperty
  a_hf_enable: assert property (p_hf_enable) else $error("high oscillator not enabled");

  property p_mf_enable;
    @(posedge clk_i) disable iff (!arst_n_i) ce_i && internal_on && ircf_mf
      |=> mf_osc_en_o && (hf_osc_en_o == $past(act_hf));
  endproperty
  a_mf_enable: assert property (p_mf_enable) else $error("mid oscillator not enabled");

  property p_pll_ref;
    @(posedge clk_i) disable iff (!arst_n_i) hf_osc_en_o |-> mf_osc_en_o && hf_pll_en_o;
  endproperty
  a_pll_ref: assert property (p_pll_ref) else $error("pll on without mid reference");

  property p_ready_off;
    @(posedge clk_i) disable iff (!arst_n_i) 1'b1 |-> (hf_osc_en_o || !status_val[4]) && (mf_osc_en_o || !status_val[3]);
  endproperty
  a_ready_off: assert property (p_ready_off) else $error("ready flag set while oscillator off");

  property p_lock_order;
    @(posedge clk_i) disable iff (!arst_n_i) status_val[0] |-> status_val[1] && status_val[4];
  endproperty
  a_lock_order: assert property (p_lock_order) else $error("stable without lock and ready");

  property p_switch_ready;
    @(posedge clk_i) disable iff (!arst_n_i) ce_i && active_q != $past(active_q) |-> $past(tgt_ready);
  endproperty
  a_switch_ready: assert property (p_switch_ready) else $error("switched to a source not ready");

  property p_sec_select;
    @(posedge clk_i) disable iff (!arst_n_i) ce_i && wr_ctrl && wdata_i[1:0] == clk_src_pkg::SCS_SECONDARY ##1 ce_i
      |=> sec_xtal_en_o;
  endproperty
  a_sec_select: assert property (p_sec_select) else $error("secondary crystal not enabled");

  property p_int_reset;
    @(posedge clk_i) disable iff (!arst_n_i) !cfg_ok_q |-> act_int;
  endproperty
  a_int_reset: assert property (p_int_reset) else $error("internal source not used after reset");

  property p_pin_free;
    @(posedge clk_i) disable iff (!arst_n_i) ce_i && act_int |=> osc_in_gpio_o;
  endproperty
  a_pin_free: assert property (p_pin_free) else $error("input pin not released");

  property p_postscale;
    @(posedge clk_i) disable iff (!arst_n_i) ce_i && act_hf |=> postscale_o == clk_src_pkg::HF_DIV_TOP - $past(ircf_q);
  endproperty
  a_postscale: assert property (p_postscale) else $error("postscale wrong for high source");

  property p_clkout;
    @(posedge clk_i) disable iff (!arst_n_i) ce_i && osc_out_free && clkout_en_q |=> osc_out_oe_o;
  endproperty
  a_clkout: assert property (p_clkout) else $error("clock out not driven");

  c_switch: cover property (@(posedge clk_i) disable iff (!arst_n_i) switch_done);
  c_to_sec: cover property (@(posedge clk_i) disable iff (!arst_n_i) active_q == clk_src_pkg::SRC_SECONDARY);
  c_hf_stable: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(status_val[0]));
  c_irq: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(irq_o));

endmodule : system_clock_source_select

/* File: inc/clk_src_pkg.sv */
// package: register map, field layout, codes and types of the system clock source selector
package clk_src_pkg;

  // register offsets (byte addresses, 8-bit data)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TUNE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] ADDR_ACTIVE = 8'h14;

  // control register fields
  localparam int unsigned CTRL_SCS_LSB = 0;
  localparam int unsigned CTRL_IRCF_LSB = 3;

  // reset values
  localparam logic [1:0] SCS_RST = 2'h0;
  localparam logic [3:0] IRCF_RST = 4'h7;
  localparam logic [5:0] TUNE_RST = 6'h00;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // source select codes
  localparam logic [1:0] SCS_CONFIG = 2'h0;
  localparam logic [1:0] SCS_SECONDARY = 2'h1;

  // configuration codes of the oscillator select word
  localparam logic [2:0] CFG_INTERNAL = 3'h4;
  localparam logic [2:0] CFG_EXT_RC = 3'h3;

  // frequency select thresholds and postscale tops
  localparam logic [3:0] IRCF_HF_MIN = 4'h8;
  localparam logic [3:0] IRCF_MF_MIN = 4'h2;
  localparam logic [3:0] HF_DIV_TOP = 4'hf;
  localparam logic [3:0] MF_DIV_TOP = 4'h7;

  // status register bit positions
  localparam int unsigned ST_HF_STABLE = 0;
  localparam int unsigned ST_HF_LOCKED = 1;
  localparam int unsigned ST_LF_READY = 2;
  localparam int unsigned ST_MF_READY = 3;
  localparam int unsigned ST_HF_READY = 4;
  localparam int unsigned ST_SEC_READY = 5;
  localparam int unsigned ST_SW_BUSY = 6;

  // interrupt event bit positions
  localparam int unsigned EV_SWITCH = 0;
  localparam int unsigned EV_HF_LOCKED = 1;
  localparam int unsigned EV_HF_STABLE = 2;
  localparam int unsigned EV_MF_READY = 3;
  localparam int unsigned EV_W = 4;

  // pin input vector layout and strap capture timing
  localparam int unsigned PIN_W = 12;
  localparam logic [1:0] CFG_CAPTURE_CYCLES = 2'h3;

  // active clock source
  typedef enum logic [2:0] {
    SRC_PRIMARY = 3'b000,
    SRC_EXT_RC = 3'b001,
    SRC_SECONDARY = 3'b010,
    SRC_HF = 3'b011,
    SRC_MF = 3'b100,
    SRC_LF = 3'b101
  } src_t;

  // switch sequencer states
  typedef enum logic [0:0] {
    SW_IDLE = 1'b0,
    SW_WAIT = 1'b1
  } sw_state_t;

endpackage : clk_src_pkg

/* File: verilog/pin_sync.sv */
// two flip-flop synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps

module pin_sync #(
  parameter int unsigned W = 1
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  genvar g;

  // one pair of flops per bit; the first flop feeds only the second
  generate
    for (g = 0; g < int'(W); g++)
    begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end
        else if (ce_i)
        begin
          meta_q <= d_i[g];
          sync_q <= meta_q;
        end
      end
      assign q_o[g] = sync_q;
    end
  endgenerate

endmodule : pin_sync

/* File: dv/system_clock_source_select_tb.sv */
// self-checking testbench of the system clock source selector
`timescale 1ns/1ps

module system_clock_source_select_tb;
  // clock, reset and register port
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  // straps, oscillator levels and pin drive
  logic [2:0] osc_select_config_i = clk_src_pkg::CFG_INTERNAL;
  logic clock_out_enable_cfg_i = 1'b1;
  logic hf_run_i = 1'b1;
  logic mf_run_i = 1'b1;
  logic lf_run_i = 1'b1;
  logic sec_xtal_run_i = 1'b0;
  logic ext_osc_run_i = 1'b1;
  logic pll_lock_coarse_i = 1'b0;
  logic pll_lock_fine_i = 1'b0;
  logic clkout_src_i = 1'b0;
  logic gpio_out_i = 1'b0;
  logic gpio_oe_i = 1'b0;
  // design outputs
  logic hf_osc_en_o, mf_osc_en_o, lf_osc_en_o, hf_pll_en_o, sec_xtal_en_o, ext_osc_en_o;
  logic [2:0] clk_src_sel_o;
  logic [3:0] postscale_o;
  logic [5:0] osc_tune_o;
  logic osc_in_gpio_o, osc_out_o, osc_out_oe_o, irq_o;
  int mismatches = 0;
  int num_checks = 0;
  logic [7:0] rv;

  system_clock_source_select dut_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .osc_select_config_i(osc_select_config_i), .clock_out_enable_cfg_i(clock_out_enable_cfg_i),
    .hf_run_i(hf_run_i), .mf_run_i(mf_run_i), .lf_run_i(lf_run_i), .sec_xtal_run_i(sec_xtal_run_i),
    .ext_osc_run_i(ext_osc_run_i), .pll_lock_coarse_i(pll_lock_coarse_i),
    .pll_lock_fine_i(pll_lock_fine_i), .clkout_src_i(clkout_src_i),
    .hf_osc_en_o(hf_osc_en_o), .mf_osc_en_o(mf_osc_en_o), .lf_osc_en_o(lf_osc_en_o),
    .hf_pll_en_o(hf_pll_en_o), .sec_xtal_en_o(sec_xtal_en_o), .ext_osc_en_o(ext_osc_en_o),
    .clk_src_sel_o(clk_src_sel_o), .postscale_o(postscale_o), .osc_tune_o(osc_tune_o),
    .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .osc_in_gpio_o(osc_in_gpio_o),
    .osc_out_o(osc_out_o), .osc_out_oe_o(osc_out_oe_o), .irq_o(irq_o)
  );

  // 250 mhz clock
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  // compare one value and count it
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  // let a number of cycles pass, then sample settled outputs
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  // reset for three cycles, then allow strap capture
  task automatic do_reset();
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    cyc(12);
  endtask : do_reset

  // wait a bounded time for the active source, then compare it
  task automatic src_wait(input logic [2:0] exp);
    for (int i = 0; i < 60; i++)
    begin
      cyc(1);
      if (clk_src_sel_o === exp)
        break;
    end
    chk("clk_src_sel", {5'h00, clk_src_sel_o}, {5'h00, exp});
  endtask : src_wait

  // select a frequency and check source and postscale
  task automatic step_freq(input logic [3:0] f, input logic [2:0] src, input logic [3:0] ps);
    wr(clk_src_pkg::ADDR_CTRL, {1'b0, f, 3'h0});
    src_wait(src);
    cyc(1);
    chk("postscale", {4'h0, postscale_o}, {4'h0, ps});
  endtask : step_freq

  // watchdog against a hang
  initial
  begin
    #(4 * 20000);
    mismatches++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    do_reset();
    // reset values and unmapped address
    rd(clk_src_pkg::ADDR_CTRL, rv);
    chk("ctrl_rst", rv, 8'h38);
    rd(clk_src_pkg::ADDR_TUNE, rv);
    chk("tune_rst", rv, 8'h00);
    rd(clk_src_pkg::ADDR_IRQ_MASK, rv);
    chk("mask_rst", rv, 8'h00);
    rd(8'h18, rv);
    chk("unmapped", rv, 8'h00);
    chk("src_rst", {5'h00, clk_src_sel_o}, {5'h00, clk_src_pkg::SRC_MF});
    chk("in_gpio", {7'h00, osc_in_gpio_o}, 8'h01);
    $display("test reset done");
    // tune register trims both internal oscillators
    wr(clk_src_pkg::ADDR_TUNE, 8'h15);
    cyc(0);
    chk("tune_out", {2'h0, osc_tune_o}, 8'h15);
    wr(clk_src_pkg::ADDR_TUNE, 8'h2a);
    rd(clk_src_pkg::ADDR_TUNE, rv);
    chk("tune_rd", rv, 8'h2a);
    // clock enable low freezes the registers
    @(posedge clk_i) ce_i <= 1'b0;
    wr(clk_src_pkg::ADDR_TUNE, 8'h3f);
    @(posedge clk_i) ce_i <= 1'b1;
    rd(clk_src_pkg::ADDR_TUNE, rv);
    chk("tune_frozen", rv, 8'h2a);
    $display("test tune done");
    // high frequency setting, pll flags
    step_freq(4'hd, clk_src_pkg::SRC_HF, 4'h2);
    chk("hf_en", {7'h00, hf_osc_en_o}, 8'h01);
    chk("mf_en", {7'h00, mf_osc_en_o}, 8'h01);
    chk("pll_en", {7'h00, hf_pll_en_o}, 8'h01);
    @(posedge clk_i) pll_lock_coarse_i <= 1'b1;
    cyc(4);
    rd(clk_src_pkg::ADDR_STATUS, rv);
    chk("st_locked", rv & 8'h1b, 8'h1a);
    @(posedge clk_i) pll_lock_fine_i <= 1'b1;
    cyc(4);
    rd(clk_src_pkg::ADDR_STATUS, rv);
    chk("st_stable", rv & 8'h1b, 8'h1b);
    // mid and low settings; hf ready must drop while hf is off
    step_freq(4'h5, clk_src_pkg::SRC_MF, 4'h2);
    step_freq(4'h0, clk_src_pkg::SRC_LF, 4'h0);
    chk("lf_en", {7'h00, lf_osc_en_o}, 8'h01);
    cyc(3);
    chk("hf_off", {7'h00, hf_osc_en_o}, 8'h00);
    rd(clk_src_pkg::ADDR_STATUS, rv);
    chk("hf_rdy_off", rv & 8'h10, 8'h00);
    $display("test freq done");
    // switch to secondary crystal, held until it runs
    wr(clk_src_pkg::ADDR_CTRL, {6'h00, clk_src_pkg::SCS_SECONDARY});
    wr(clk_src_pkg::ADDR_IRQ_STAT, 8'h01);
    cyc(10);
    chk("sec_en", {7'h00, sec_xtal_en_o}, 8'h01);
    chk("src_held", {5'h00, clk_src_sel_o}, {5'h00, clk_src_pkg::SRC_LF});
    rd(clk_src_pkg::ADDR_STATUS, rv);
    chk("sw_busy", rv & 8'h60, 8'h40);
    @(posedge clk_i) sec_xtal_run_i <= 1'b1;
    src_wait(clk_src_pkg::SRC_SECONDARY);
    rd(clk_src_pkg::ADDR_ACTIVE, rv);
    chk("active_rd", rv, {5'h00, clk_src_pkg::SRC_SECONDARY});
    cyc(3);
    // low source stays on: configuration internal with a low frequency select
    chk("lf_kept", {7'h00, lf_osc_en_o}, 8'h01);
    // switch-done event: masked, unmasked, cleared
    rd(clk_src_pkg::ADDR_IRQ_STAT, rv);
    chk("irq_stat", rv & 8'h01, 8'h01);
    chk("irq_masked", {7'h00, irq_o}, 8'h00);
    wr(clk_src_pkg::ADDR_IRQ_MASK, 8'h01);
    cyc(2);
    chk("irq_on", {7'h00, irq_o}, 8'h01);
    wr(clk_src_pkg::ADDR_IRQ_STAT, 8'h01);
    cyc(2);
    chk("irq_off", {7'h00, irq_o}, 8'h00);
    rd(clk_src_pkg::ADDR_IRQ_STAT, rv);
    chk("irq_clr", rv & 8'h01, 8'h00);
    $display("test secondary done");
    // upper select bit picks the internal block
    wr(clk_src_pkg::ADDR_CTRL, 8'h6a);
    src_wait(clk_src_pkg::SRC_HF);
    cyc(3);
    chk("sec_off", {7'h00, sec_xtal_en_o}, 8'h00);
    chk("lf_off", {7'h00, lf_osc_en_o}, 8'h00);
    $display("test internal select done");
    // clock output on the output pin
    @(posedge clk_i) clkout_src_i <= 1'b1;
    cyc(4);
    chk("clkout_hi", {6'h00, osc_out_oe_o, osc_out_o}, 8'h03);
    @(posedge clk_i) clkout_src_i <= 1'b0;
    cyc(4);
    chk("clkout_lo", {6'h00, osc_out_oe_o, osc_out_o}, 8'h02);
    $display("test clock out done");
    // external rc: input pin kept, output pin is general io
    @(posedge clk_i) osc_select_config_i <= clk_src_pkg::CFG_EXT_RC;
    clock_out_enable_cfg_i <= 1'b0;
    gpio_out_i <= 1'b1;
    gpio_oe_i <= 1'b1;
    do_reset();
    src_wait(clk_src_pkg::SRC_EXT_RC);
    chk("rc_in_pin", {7'h00, osc_in_gpio_o}, 8'h00);
    chk("rc_gpio_hi", {6'h00, osc_out_oe_o, osc_out_o}, 8'h03);
    @(posedge clk_i) gpio_out_i <= 1'b0;
    cyc(3);
    chk("rc_gpio_lo", {6'h00, osc_out_oe_o, osc_out_o}, 8'h02);
    chk("rc_ext_en", {7'h00, ext_osc_en_o}, 8'h01);
    rd(clk_src_pkg::ADDR_TUNE, rv);
    chk("tune_rst2", rv, 8'h00);
    $display("test ext rc done");
    wrap_up();
  end

endmodule : system_clock_source_select_tb
